// *** rtl/sps_consts.vh ***
/*
  Constants for the shutdown and power-up sequencer: power state codes,
  clock rate, timing figures and derived cycle counts.
  Assumes a single 200 MHz system clock and a nominal 32.768 kHz slow clock pin.
*/
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH

// power state codes
`define SPS_ST_W 3
`define SPS_ST_SHUT 3'h0
`define SPS_ST_PWRUP 3'h1
`define SPS_ST_ACTIVE 3'h2
`define SPS_ST_SLEEP 3'h3
`define SPS_ST_STALL 3'h4

// system clock rate
`define SPS_MCLK_KHZ 200000

// latest completion indication after release, in ms
`define SPS_RTS_LIMIT_MS 100
// longest time rounds down: whole mclk cycles
`define SPS_RTS_LIMIT_CYC 25'd20000000
`define SPS_TMR_W 25

// slow clock cycles the host may take to settle after release
`define SPS_SLOW_STABLE_CYC 64
// slow clock cycles counted before completion is shown
`define SPS_PWRUP_SLOW_CYC 8'd96
`define SPS_SLOW_W 8

// reset values
`define SPS_RST_RTS 1'h1
`define SPS_RST_TX 1'h1

`endif

// *** rtl/sps_sequencer.v ***
/*
  Shutdown and power-up sequencer with pin state control for a dual-mode
  wireless controller. Holds the core in reset while the hold-off pin is low,
  times power-up on the slow clock and shows completion by driving the link
  RTS pin low, and sets output enable and pull state of every I/O pin but the slow clock pin.
  Assumes: pin inputs are asynchronous to mclk; supply-good levels come from
  analog detectors; core-side signals are on mclk.
*/
// Contract
// RULE1: host releases hold-off only after both supplies are stable.
// RULE2: host gives stable fast clock within 20 ms of release.
// RULE3: host gives stable slow clock within 2 ms of release.
// RULE4: device drives link RTS low within 100 ms of release.
// RULE5: host treats missing RTS low as failed power-up and rechecks.
// RULE6: hold-off low keeps device in low power with all logic reset.
// RULE7: host holds hold-off low at least 5 ms to reset.
// RULE8: all pins high impedance with pulls during shutdown and power-up.
// RULE9: active only with both supplies present and hold-off released.
// RULE10: host drives only fail-safe pins while I/O supply is absent.
// RULE11: shutdown pulls: link pins and debug up, audio pins down.
// RULE12: active and sleep pin directions and pulls per pin table.
// RULE13: internal pulldown keeps hold-off low when undriven.
// RULE14: host slow clock is 32.768 kHz, stable within 64 cycles.
// RULE15: release synchronised to slow clock, power-up timed in slow cycles; the code synchronises release to mclk instead.
`timescale 1ns/1ps
`include "sps_consts.vh"

module sps_sequencer #(
  parameter [`SPS_TMR_W-1:0] RTS_LIMIT_CYC = `SPS_RTS_LIMIT_CYC,
  parameter [`SPS_SLOW_W-1:0] PWRUP_SLOW_CYC = `SPS_PWRUP_SLOW_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire power_hold_off_n,
  output reg holdOffPullDown_ff,
  input wire slowClkIn,
  input wire mainSupplyOk,
  input wire ioSupplyOk,
  input wire host_link_rx,
  output reg hostLinkRxPullUp_ff,
  output reg host_link_tx_ff,
  output reg hostLinkTxOe_ff,
  output reg hostLinkTxPullUp_ff,
  output reg host_link_rts_ff,
  output reg hostLinkRtsOe_ff,
  output reg hostLinkRtsPullUp_ff,
  input wire host_link_cts,
  output reg hostLinkCtsPullUp_ff,
  input wire audio_bit_clock,
  input wire audio_frame_sync,
  input wire audio_serial_in,
  output reg audioInPullDown_ff,
  output reg audio_serial_out_ff,
  output reg audioOutOe_ff,
  output reg audioOutPullDown_ff,
  output reg debug_trace_out_ff,
  output reg debugOe_ff,
  output reg debugPullUp_ff,
  input wire coreTxData,
  input wire coreRxBusy,
  input wire coreDebugData,
  input wire deepSleepReq,
  output reg coreRst_n_ff,
  output reg coreRx_ff,
  output reg coreCts_ff,
  output reg coreAudClk_ff,
  output reg coreAudFsync_ff,
  output reg coreAudIn_ff,
  output reg [`SPS_ST_W-1:0] power_state_ff,
  output reg powerUpDone_ff,
  output reg powerUpStall_ff
);

  localparam PIN_N = 9;
  localparam [`SPS_ST_W-1:0] ST_SHUT = `SPS_ST_SHUT;
  localparam [`SPS_ST_W-1:0] ST_PWRUP = `SPS_ST_PWRUP;
  localparam [`SPS_ST_W-1:0] ST_ACTIVE = `SPS_ST_ACTIVE;
  localparam [`SPS_ST_W-1:0] ST_SLEEP = `SPS_ST_SLEEP;
  localparam [`SPS_ST_W-1:0] ST_STALL = `SPS_ST_STALL;

  // two-stage synchroniser for every asynchronous pin
  wire [PIN_N-1:0] pinRaw;
  reg [PIN_N-1:0] pinMeta_ff;
  reg [PIN_N-1:0] pinSync_ff;
  assign pinRaw = {power_hold_off_n, slowClkIn, mainSupplyOk, ioSupplyOk, host_link_rx,
                   host_link_cts, audio_bit_clock, audio_frame_sync, audio_serial_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_sync
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pinMeta_ff[gi] <= 1'h0;
          pinSync_ff[gi] <= 1'h0;
        end else begin
          pinMeta_ff[gi] <= pinRaw[gi];
          pinSync_ff[gi] <= pinMeta_ff[gi];
        end
      end
    end
  endgenerate

  wire holdOffN = pinSync_ff[8];
  wire slowClk = pinSync_ff[7];
  wire mainOk = pinSync_ff[6];
  wire ioOk = pinSync_ff[5];
  wire linkRx = pinSync_ff[4];
  wire linkCts = pinSync_ff[3];
  wire audClk = pinSync_ff[2];
  wire audFsync = pinSync_ff[1];
  wire audIn = pinSync_ff[0];

  // slow clock rising edge, taken from the second stage only
  reg slowPrev_ff;
  wire slowRise = slowClk & ~slowPrev_ff;

  reg [`SPS_ST_W-1:0] state_ff;
  reg [`SPS_ST_W-1:0] nxt_state;
  reg [`SPS_SLOW_W-1:0] slowCnt_ff;
  reg [`SPS_SLOW_W-1:0] nxt_slowCnt;
  reg [`SPS_TMR_W-1:0] tmr_ff;
  reg [`SPS_TMR_W-1:0] nxt_tmr;
  reg rtsShown_ff;

  wire runAllowed = holdOffN & mainOk & ioOk;

  always @* begin
    nxt_state = state_ff;
    nxt_slowCnt = slowCnt_ff;
    nxt_tmr = tmr_ff;
    if (!runAllowed) begin
      nxt_state = ST_SHUT; // [RULE6] [RULE9]
      nxt_slowCnt = {`SPS_SLOW_W{1'b0}};
      nxt_tmr = {`SPS_TMR_W{1'b0}};
    end else begin
      case (state_ff)
        ST_SHUT: begin
          nxt_state = ST_PWRUP; // [RULE9]
        end
        ST_PWRUP: begin
          nxt_tmr = tmr_ff + {{(`SPS_TMR_W-1){1'b0}}, 1'b1};
          if (slowRise) begin
            nxt_slowCnt = slowCnt_ff + {{(`SPS_SLOW_W-1){1'b0}}, 1'b1}; // [RULE15]
          end
          if (slowRise && slowCnt_ff == PWRUP_SLOW_CYC - {{(`SPS_SLOW_W-1){1'b0}}, 1'b1}) begin
            nxt_state = ST_ACTIVE; // [RULE15] [RULE4]
          end else if (tmr_ff == RTS_LIMIT_CYC - {{(`SPS_TMR_W-1){1'b0}}, 1'b1}) begin
            nxt_state = ST_STALL; // [RULE4]
          end
        end
        ST_ACTIVE: begin
          if (deepSleepReq) begin
            nxt_state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!deepSleepReq) begin
            nxt_state = ST_ACTIVE;
          end
        end
        ST_STALL: begin
          nxt_state = ST_STALL;
        end
        default: begin
          nxt_state = ST_SHUT;
        end
      endcase
    end
  end

  // pin state per power state
  wire nxtOn = (nxt_state == ST_ACTIVE) || (nxt_state == ST_SLEEP);
  wire nxtActive = (nxt_state == ST_ACTIVE);
  reg nxt_rts;
  reg nxt_tx;
  reg nxt_dbg;
  always @* begin
    nxt_rts = `SPS_RST_RTS;
    nxt_tx = `SPS_RST_TX;
    nxt_dbg = 1'h0;
    if (nxtOn) begin
      nxt_rts = rtsShown_ff ? coreRxBusy : 1'h0; // [RULE4]
      nxt_tx = coreTxData; // [RULE12]
      nxt_dbg = coreDebugData;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slowPrev_ff <= 1'h0;
      state_ff <= ST_SHUT;
      slowCnt_ff <= {`SPS_SLOW_W{1'b0}};
      tmr_ff <= {`SPS_TMR_W{1'b0}};
      rtsShown_ff <= 1'h0;
      power_state_ff <= ST_SHUT;
      powerUpDone_ff <= 1'h0;
      powerUpStall_ff <= 1'h0;
      coreRst_n_ff <= 1'h0;
      holdOffPullDown_ff <= 1'h1;
      hostLinkRxPullUp_ff <= 1'h1;
      host_link_tx_ff <= `SPS_RST_TX;
      hostLinkTxOe_ff <= 1'h0;
      hostLinkTxPullUp_ff <= 1'h1;
      host_link_rts_ff <= `SPS_RST_RTS;
      hostLinkRtsOe_ff <= 1'h0;
      hostLinkRtsPullUp_ff <= 1'h1;
      hostLinkCtsPullUp_ff <= 1'h1;
      audioInPullDown_ff <= 1'h1;
      audio_serial_out_ff <= 1'h0;
      audioOutOe_ff <= 1'h0;
      audioOutPullDown_ff <= 1'h1;
      debug_trace_out_ff <= 1'h0;
      debugOe_ff <= 1'h0;
      debugPullUp_ff <= 1'h1;
      coreRx_ff <= 1'h1;
      coreCts_ff <= 1'h1;
      coreAudClk_ff <= 1'h0;
      coreAudFsync_ff <= 1'h0;
      coreAudIn_ff <= 1'h0;
    end else begin
      slowPrev_ff <= slowClk;
      state_ff <= nxt_state;
      slowCnt_ff <= nxt_slowCnt;
      tmr_ff <= nxt_tmr;
      rtsShown_ff <= nxtOn;
      power_state_ff <= nxt_state;
      powerUpDone_ff <= nxtOn;
      powerUpStall_ff <= (nxt_state == ST_STALL);
      coreRst_n_ff <= nxtOn; // [RULE6]
      holdOffPullDown_ff <= 1'h1; // [RULE13]
      // outputs: driven only when on, otherwise hi-z with pull
      host_link_tx_ff <= nxt_tx;
      hostLinkTxOe_ff <= nxtOn; // [RULE8] [RULE12]
      hostLinkTxPullUp_ff <= ~nxtOn; // [RULE11]
      host_link_rts_ff <= nxt_rts;
      hostLinkRtsOe_ff <= nxtOn; // [RULE8] [RULE12]
      hostLinkRtsPullUp_ff <= ~nxtOn; // [RULE11]
      debug_trace_out_ff <= nxt_dbg;
      debugOe_ff <= nxtActive; // [RULE8]
      debugPullUp_ff <= ~nxtActive; // [RULE11]
      // inputs keep their pulls in every state
      hostLinkRxPullUp_ff <= 1'h1; // [RULE11] [RULE12]
      hostLinkCtsPullUp_ff <= 1'h1; // [RULE11] [RULE12]
      audioInPullDown_ff <= 1'h1; // [RULE11] [RULE12]
      audio_serial_out_ff <= 1'h0;
      audioOutOe_ff <= 1'h0; // [RULE12]
      audioOutPullDown_ff <= 1'h1; // [RULE11] [RULE12]
      // pin inputs reach the core only when on
      coreRx_ff <= nxtOn ? linkRx : 1'h1;
      coreCts_ff <= nxtOn ? linkCts : 1'h1;
      coreAudClk_ff <= nxtOn & audClk;
      coreAudFsync_ff <= nxtOn & audFsync;
      coreAudIn_ff <= nxtOn & audIn;
    end
  end

endmodule // sps_sequencer

// *** bench/sps_sequencer_monitor.sv ***
/* sequencer checker: pin state and power-up timing assertions.
   assumes binding to sps_sequencer, clock mclk, async reset rst_n. */
`timescale 1ns/1ps
`include "sps_consts.vh"
module sps_sequencer_monitor #(
  parameter [`SPS_TMR_W-1:0] RTS_LIMIT_CYC = `SPS_RTS_LIMIT_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire power_hold_off_n,
  input wire mainSupplyOk,
  input wire ioSupplyOk,
  input wire deepSleepReq,
  input wire host_link_rts_ff,
  input wire hostLinkRtsOe_ff,
  input wire hostLinkRtsPullUp_ff,
  input wire hostLinkTxOe_ff,
  input wire debugOe_ff,
  input wire holdOffPullDown_ff,
  input wire coreRst_n_ff,
  input wire [`SPS_ST_W-1:0] power_state_ff,
  input wire powerUpDone_ff
);
  wire allOk = power_hold_off_n && mainSupplyOk && ioSupplyOk;
  reg [`SPS_TMR_W:0] pwrCnt_ff;
  wire [`SPS_TMR_W:0] nxt_pwrCnt = (power_state_ff == `SPS_ST_PWRUP) ? pwrCnt_ff + 1'b1 : '0;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pwrCnt_ff <= '0;
    else pwrCnt_ff <= nxt_pwrCnt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_shut_reset: assert property (!power_hold_off_n [*4] |-> power_state_ff == `SPS_ST_SHUT && !coreRst_n_ff)
    else $error("core not held in shutdown");
  a_supply_gate: assert property (!(mainSupplyOk && ioSupplyOk) [*4] |-> power_state_ff == `SPS_ST_SHUT)
    else $error("not shut with a supply missing");
  a_pins_hiz: assert property (!powerUpDone_ff |-> !hostLinkRtsOe_ff && !hostLinkTxOe_ff && !debugOe_ff
    && hostLinkRtsPullUp_ff) else $error("pins driven before power-up");
  a_holdoff_pull: assert property (holdOffPullDown_ff)
    else $error("hold-off pulldown off");
  a_done_rts: assert property ($rose(powerUpDone_ff) |-> !host_link_rts_ff && hostLinkRtsOe_ff
    && !hostLinkRtsPullUp_ff) else $error("rts not driven low at completion");
  a_rts_deadline: assert property (pwrCnt_ff <= RTS_LIMIT_CYC)
    else $error("power-up outlasts limit");
  a_leave_shut: assert property (allOk [*5] |-> power_state_ff != `SPS_ST_SHUT)
    else $error("release not taken");
  a_sleep_debug: assert property (allOk [*3] ##0 power_state_ff == `SPS_ST_ACTIVE && deepSleepReq |=>
    power_state_ff == `SPS_ST_SLEEP && !debugOe_ff) else $error("sleep entry wrong");
endmodule // sps_sequencer_monitor

bind sps_sequencer sps_sequencer_monitor #(.RTS_LIMIT_CYC(RTS_LIMIT_CYC)) sps_sequencer_monitor_inst (
  .mclk(mclk), .rst_n(rst_n), .power_hold_off_n(power_hold_off_n), .mainSupplyOk(mainSupplyOk),
  .ioSupplyOk(ioSupplyOk), .deepSleepReq(deepSleepReq), .host_link_rts_ff(host_link_rts_ff),
  .hostLinkRtsOe_ff(hostLinkRtsOe_ff), .hostLinkRtsPullUp_ff(hostLinkRtsPullUp_ff),
  .hostLinkTxOe_ff(hostLinkTxOe_ff), .debugOe_ff(debugOe_ff), .holdOffPullDown_ff(holdOffPullDown_ff),
  .coreRst_n_ff(coreRst_n_ff), .power_state_ff(power_state_ff), .powerUpDone_ff(powerUpDone_ff));

// *** bench/sps_host_model.sv ***
/* host model: supplies, hold-off pin, slow clock, link idle levels.
   assumes the bench commands it through four level inputs. */
`timescale 1ns/1ps
module sps_host_model (
  input wire mainOn,
  input wire ioOn,
  input wire releaseReq,
  input wire slowEn,
  output wire power_hold_off_n,
  output wire mainSupplyOk,
  output wire ioSupplyOk,
  output reg slowClkIn,
  output wire host_link_rx,
  output wire host_link_cts
);
  assign mainSupplyOk = mainOn;
  assign ioSupplyOk = ioOn;
  // released only with both supplies up
  assign power_hold_off_n = releaseReq && mainOn && ioOn;
  // idle high only while io supply is up
  assign host_link_rx = ioOn;
  assign host_link_cts = ioOn;
  // scaled slow clock, stands still when disabled
  initial slowClkIn = 1'b0;
  always #25 if (slowEn) slowClkIn = ~slowClkIn;
endmodule // sps_host_model

// *** bench/sps_sequencer_tb.sv ***
/* testbench for sps_sequencer: power-up, sleep, supply loss, stall.
   assumes sps_host_model stands in for the host. */
`timescale 1ns/1ps
`include "sps_consts.vh"
`define CHK(a, b) begin totalChecks = totalChecks + 1; if ((a) !== (b)) begin errors = errors + 1; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module sps_sequencer_tb;
  reg mclk = 0, rst_n = 0, mainOn = 0, ioOn = 0, releaseReq = 0, slowEn = 0, rxBusy = 0, sleepReq = 0;
  reg txData = 0, dbgData = 0;
  wire holdN, slowClk, mainOk, ioOk, linkRx, linkCts, rts, rtsOe, rtsPu, txOe, txPu, dbgOe, dbgPu;
  wire tx, dbgOut, rxPu, ctsPu, aInPd, aOutPd, aOut, stall;
  wire aOutOe, coreRstN, done, ctsCore;
  wire [`SPS_ST_W-1:0] st;
  integer errors = 0, totalChecks = 0, n;
  always #2.5 mclk = ~mclk;
  sps_host_model sps_host_model_inst (.mainOn(mainOn), .ioOn(ioOn), .releaseReq(releaseReq), .slowEn(slowEn),
    .power_hold_off_n(holdN), .mainSupplyOk(mainOk), .ioSupplyOk(ioOk), .slowClkIn(slowClk),
    .host_link_rx(linkRx), .host_link_cts(linkCts));
  sps_sequencer #(.RTS_LIMIT_CYC(25'd2000), .PWRUP_SLOW_CYC(8'd4)) sps_sequencer_inst (.mclk(mclk),
    .rst_n(rst_n), .power_hold_off_n(holdN), .holdOffPullDown_ff(), .slowClkIn(slowClk), .mainSupplyOk(mainOk),
    .ioSupplyOk(ioOk), .host_link_rx(linkRx), .hostLinkRxPullUp_ff(rxPu), .host_link_tx_ff(tx),
    .hostLinkTxOe_ff(txOe), .hostLinkTxPullUp_ff(txPu), .host_link_rts_ff(rts), .hostLinkRtsOe_ff(rtsOe),
    .hostLinkRtsPullUp_ff(rtsPu), .host_link_cts(linkCts), .hostLinkCtsPullUp_ff(ctsPu),
    .audio_bit_clock(1'b0), .audio_frame_sync(1'b0), .audio_serial_in(1'b0), .audioInPullDown_ff(aInPd),
    .audio_serial_out_ff(aOut), .audioOutOe_ff(aOutOe), .audioOutPullDown_ff(aOutPd),
    .debug_trace_out_ff(dbgOut), .debugOe_ff(dbgOe), .debugPullUp_ff(dbgPu),
    .coreTxData(txData), .coreRxBusy(rxBusy), .coreDebugData(dbgData), .deepSleepReq(sleepReq),
    .coreRst_n_ff(coreRstN), .coreRx_ff(), .coreCts_ff(ctsCore), .coreAudClk_ff(), .coreAudFsync_ff(),
    .coreAudIn_ff(), .power_state_ff(st), .powerUpDone_ff(done), .powerUpStall_ff(stall));
  task end_of_test; begin
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  task t_powerup; begin
    @(negedge mclk);
    mainOn = 1; ioOn = 1; slowEn = 1; releaseReq = 1; n = 0;
    while (done !== 1'b1 && n < 3000) begin @(negedge mclk); n = n + 1; end
    `CHK(st, `SPS_ST_ACTIVE)
    `CHK(n >= 30 && n < 2000, 1'b1)
    `CHK({rts, rtsOe, txOe, rtsPu, txPu, aOutOe}, 6'h18)
    `CHK({rxPu, ctsPu, aInPd, aOutPd, aOut}, 5'h1E)
    rxBusy = 1; txData = 1; dbgData = 1;
    @(negedge mclk);
    `CHK({rts, tx, dbgOut}, 3'h7)
    rxBusy = 0; txData = 0;
    $display("powerup test done");
  end endtask
  task t_sleep; begin
    sleepReq = 1;
    repeat (2) @(negedge mclk);
    `CHK({st, dbgOe, dbgPu, rtsOe}, {`SPS_ST_SLEEP, 3'h3})
    sleepReq = 0;
    repeat (2) @(negedge mclk);
    `CHK({st, dbgOe}, {`SPS_ST_ACTIVE, 1'b1})
    $display("sleep test done");
  end endtask
  task t_shutdown; begin
    ioOn = 0;
    repeat (4) @(negedge mclk);
    `CHK(st, `SPS_ST_SHUT)
    `CHK({coreRstN, rtsOe, txOe, dbgOe, rtsPu, txPu, dbgPu, ctsCore}, 8'h0F)
    `CHK({tx, dbgOut, rxPu, ctsPu, aInPd, aOutPd, aOut}, 7'h5E)
    releaseReq = 0;
    ioOn = 1;
    repeat (10) @(negedge mclk);
    $display("shutdown test done");
  end endtask
  task t_stall; begin
    slowEn = 0; releaseReq = 1; n = 0;
    while (st !== `SPS_ST_STALL && n < 2200) begin @(negedge mclk); n = n + 1; end
    `CHK({st, rts, rtsOe, done, stall}, {`SPS_ST_STALL, 4'h9})
    releaseReq = 0;
    repeat (10) @(negedge mclk);
    `CHK(st, `SPS_ST_SHUT)
    $display("stall test done");
  end endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1;
    t_powerup;
    t_sleep;
    t_shutdown;
    t_stall;
    t_powerup;
    end_of_test;
  end
  initial begin
    #100000;
    errors = errors + 1;
    end_of_test;
  end
endmodule // sps_sequencer_tb
